/* File: core/refclk_regs.svh */
// Register offsets, field positions, reset values and counts of the reference clock block.
`ifndef REFCLK_REGS_SVH
`define REFCLK_REGS_SVH

// Byte offsets inside the slave's address window.
`define REFCLK_CTRL_OFS      8'h00
`define REFCLK_STAT_OFS      8'h04

// Control register fields.
`define REFCLK_ON_BIT        7
`define REFCLK_PIN_BIT       6
`define REFCLK_SLEW_BIT      5
`define REFCLK_DUTY_MSB      4
`define REFCLK_DUTY_LSB      3
`define REFCLK_DIV_MSB       2
`define REFCLK_DIV_LSB       0
`define REFCLK_CTRL_RST      8'h30

// Status register fields.
`define REFCLK_ST_REF_BIT    0
`define REFCLK_ST_PIN_O_BIT  1
`define REFCLK_ST_PIN_OE_BIT 2
`define REFCLK_ST_XTAL_BIT   3
`define REFCLK_ST_ICLK_BIT   4
`define REFCLK_ST_SLEEP_BIT  5
`define REFCLK_ST_RUN_BIT    6

// Instruction clock is the system clock divided by this count.
`define REFCLK_ICLK_DIV      4
// Stages of every pin synchroniser.
`define REFCLK_SYNC_STAGES   2
// Widest division ratio is two to this power.
`define REFCLK_DIV_LOG_MAX   7

`endif

/* File: core/refclk_pkg.sv */
// Types shared by the reference clock block and its bench.
package refclk_pkg;

	// Control register layout, bit 7 first.
	typedef struct packed {
		logic       module_on_bit;
		logic       pin_drive_bit;
		logic       slew_limit_bit;
		logic [1:0] duty_select_field;
		logic [2:0] divide_select_field;
	} ctrl_t;

	// Oscillator configuration as seen on the configuration pins.
	typedef enum logic [2:0] {
		OSC_LOW_POWER_CRYSTAL  = 3'h0,
		OSC_STANDARD_CRYSTAL   = 3'h1,
		OSC_HIGH_SPEED_CRYSTAL = 3'h2,
		OSC_EXTERNAL_CLOCK     = 3'h3,
		OSC_INTERNAL           = 3'h4
	} osc_mode_t;

	// Who owns the shared pin.
	typedef enum logic [3:0] {
		PIN_IDLE      = 4'h1,
		PIN_OSC_INPUT = 4'h2,
		PIN_INSTR_CLK = 4'h4,
		PIN_REF_CLK   = 4'h8
	} pin_src_t;

	// Address phase of an AHB-Lite transfer held for its data phase.
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] offset;
	} ahb_aphase_t;

	// Driven levels of the shared pin.
	typedef struct packed {
		logic o;
		logic oe;
	} pin_drive_t;

endpackage

/* File: core/refclk_gen.sv */
// Reference clock generator with AHB-Lite control register and shared pin arbitration.
`timescale 1ns/1ps
`include "refclk_regs.svh"

module refclk_gen #(
	parameter int ADDR_W = 8
) (
	// Clock and reset.
	input  wire logic                  CLK,
	input  wire logic                  RST,
	// AHB-Lite slave.
	input  wire logic                  HSEL,
	input  wire logic [31:0]           HADDR,
	input  wire logic [1:0]            HTRANS,
	input  wire logic                  HWRITE,
	input  wire logic [2:0]            HSIZE,
	input  wire logic [31:0]           HWDATA,
	input  wire logic                  HREADY,
	output logic      [31:0]           HRDATA,
	output logic                       HREADYOUT,
	output logic                       HRESP,
	// Device configuration and power state, all from outside this clock.
	input  wire refclk_pkg::osc_mode_t OSC_MODE,
	input  wire logic                  INSTRUCTION_CLOCK_OUTPUT_CONFIG,
	input  wire logic                  SLEEP,
	// Shared oscillator / reference clock pin.
	output logic                       DIVIDED_CLOCK_PIN_O,
	output logic                       DIVIDED_CLOCK_PIN_OE,
	output logic                       SLEW_LIMIT,
	output logic                       OSC_PIN_IS_INPUT,
	// Generated clock toward the modulator.
	output logic                       MOD_REF_CLK
);
	import refclk_pkg::*;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;
	localparam int         SYNC_N        = `REFCLK_SYNC_STAGES;
	localparam int         CNT_W         = `REFCLK_DIV_LOG_MAX;

	// Division ratio in cycles of the system clock.
	function automatic logic [CNT_W:0] period_of(input logic [2:0] div);
		period_of = (CNT_W+1)'(1) << div;
	endfunction

	// High time in cycles; below four cycles the quarter steps cannot be exact.
	// With no division a register cannot copy the source waveform, so any nonzero duty is
	// held high to stand for it; at divide by two every nonzero duty gives one high cycle,
	// which keeps 50 percent exact and lets 25 and 75 percent fall back to it.
	function automatic logic [CNT_W:0] high_of(input logic [2:0] div, input logic [1:0] duty);
		logic [CNT_W+2:0] prod;
		logic [CNT_W:0]   p;
		logic [CNT_W:0]   h;
		p    = period_of(div);
		prod = (CNT_W+3)'(p) * (CNT_W+3)'(duty);
		h    = prod[CNT_W+2:2];
		if (duty == 2'h0) begin
			h = '0;
		end else if (p == (CNT_W+1)'(1)) begin
			h = (CNT_W+1)'(1);
		end else if (p == (CNT_W+1)'(2)) begin
			h = (CNT_W+1)'(1);
		end
		high_of = h;
	endfunction

	// True for the three crystal modes that keep the pin as an oscillator input.
	function automatic logic is_crystal(input osc_mode_t m);
		is_crystal = (m == OSC_LOW_POWER_CRYSTAL) || (m == OSC_STANDARD_CRYSTAL) ||
		             (m == OSC_HIGH_SPEED_CRYSTAL);
	endfunction

	// Synchronisers for the pin inputs; the mode word is synchronised raw, decoded after.
	logic [SYNC_N-1:0][2:0] osc_sync_r;
	logic [SYNC_N-1:0] cfg_sync_r;
	logic [SYNC_N-1:0] sleep_sync_r;
	logic [SYNC_N-1:0] settle_r;
	logic              xtal_s;
	logic              cfg_s;
	logic              sleep_s;
	logic              settled;

	// Bus side.
	ahb_aphase_t       aph_r;
	ahb_aphase_t       aph_nxt;
	ctrl_t             ctrl_r;
	ctrl_t             ctrl_nxt;
	logic              ctrl_wr;
	logic [31:0]       rdata_nxt;
	logic [31:0]       status_word;

	// Generator.
	logic [CNT_W-1:0]  cnt_r;
	logic [CNT_W-1:0]  cnt_nxt;
	logic [1:0]        iclk_cnt_r;
	logic [CNT_W:0]    period;
	logic [CNT_W:0]    high;
	logic              ref_nxt;
	logic              ref_r;
	pin_src_t          pin_src_nxt;
	pin_drive_t        pin_nxt;
	pin_drive_t        pin_r;

	// Configuration pins are static in practice but still cross into this clock. The mode
	// pins pass the flops as one raw word and are decoded behind them; they are meant to
	// change only in reset, where the settle delay hides any mixed code in flight.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			osc_sync_r   <= '0;
			cfg_sync_r   <= '0;
			sleep_sync_r <= '0;
		end else begin
			osc_sync_r   <= {osc_sync_r[SYNC_N-2:0], OSC_MODE};
			cfg_sync_r   <= {cfg_sync_r[SYNC_N-2:0], INSTRUCTION_CLOCK_OUTPUT_CONFIG};
			sleep_sync_r <= {sleep_sync_r[SYNC_N-2:0], SLEEP};
		end
	end

	assign xtal_s  = is_crystal(osc_mode_t'(osc_sync_r[SYNC_N-1]));
	assign cfg_s   = cfg_sync_r[SYNC_N-1];
	assign sleep_s = sleep_sync_r[SYNC_N-1];

	// The pin stays undriven until the synchronisers hold real values, so a crystal never
	// sees a stray drive right after reset.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			settle_r <= '0;
		end else begin
			settle_r <= {settle_r[SYNC_N-2:0], 1'b1};
		end
	end

	assign settled = settle_r[SYNC_N-1];

	// Address phase capture; only whole-word nonsequential transfers are taken.
	// Only the low address byte is decoded, so the register window repeats every 256 bytes.
	always_comb begin
		aph_nxt = '0;
		if (HSEL && HREADY && (HTRANS == HTRANS_NONSEQ) && (HSIZE == HSIZE_WORD)) begin
			aph_nxt.valid  = 1'b1;
			aph_nxt.write  = HWRITE;
			aph_nxt.offset = HADDR[7:0];
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			aph_r <= '0;
		end else begin
			aph_r <= aph_nxt;
		end
	end

	// Control register is written in the data phase from the low byte lane.
	assign ctrl_wr = aph_r.valid && aph_r.write && (aph_r.offset == `REFCLK_CTRL_OFS);

	always_comb begin
		ctrl_nxt = ctrl_r;
		if (ctrl_wr) begin
			ctrl_nxt = ctrl_t'(HWDATA[7:0]);
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ctrl_r <= ctrl_t'(`REFCLK_CTRL_RST);
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// Status shows the live state of the generator and of the pin owner.
	// It is read only; a write to it is dropped like one to an unmapped offset.
	always_comb begin
		status_word                        = '0;
		status_word[`REFCLK_ST_REF_BIT]    = ref_r;
		status_word[`REFCLK_ST_PIN_O_BIT]  = pin_r.o;
		status_word[`REFCLK_ST_PIN_OE_BIT] = pin_r.oe;
		status_word[`REFCLK_ST_XTAL_BIT]   = xtal_s;
		status_word[`REFCLK_ST_ICLK_BIT]   = ~cfg_s;
		status_word[`REFCLK_ST_SLEEP_BIT]  = sleep_s;
		status_word[`REFCLK_ST_RUN_BIT]    = ctrl_r.module_on_bit && !sleep_s;
	end

	// Read data is loaded at the address phase so it stands through the data phase. It uses
	// the next control value, so a read right behind a write sees the new contents.
	always_comb begin
		rdata_nxt = HRDATA;
		if (aph_nxt.valid && !aph_nxt.write) begin
			unique case (aph_nxt.offset)
				`REFCLK_CTRL_OFS: rdata_nxt = {24'h000000, ctrl_nxt};
				`REFCLK_STAT_OFS: rdata_nxt = status_word;
				default:          rdata_nxt = 32'h00000000;
			endcase
		end
	end

	// Zero wait states and always OKAY; unmapped reads give zero and writes are dropped.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			HRDATA    <= 32'h00000000;
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end else begin
			HRDATA    <= rdata_nxt;
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end
	end

	// The generator runs from the system clock alone, the oscillator mode never changes it.
	assign period = period_of(ctrl_r.divide_select_field);
	assign high   = high_of(ctrl_r.divide_select_field, ctrl_r.duty_select_field);

	// Any write to the control register outside Sleep restarts the period so a new ratio starts clean.
	// The write cycle itself is forced low, so the first high phase after a write is one
	// cycle short; software that needs exact first pulses must allow for it.
	always_comb begin
		cnt_nxt = cnt_r;
		if (!ctrl_r.module_on_bit || ctrl_wr) begin
			cnt_nxt = '0;
		end else if ((CNT_W+1)'(cnt_r) >= period - (CNT_W+1)'(1)) begin
			cnt_nxt = '0;
		end else begin
			cnt_nxt = cnt_r + CNT_W'(1);
		end
	end

	// High for the first part of the period, held low when off or at zero duty.
	always_comb begin
		ref_nxt = 1'b0;
		if (ctrl_r.module_on_bit && !ctrl_wr) begin
			ref_nxt = (CNT_W+1)'(cnt_nxt) < high;
		end
	end

	// Instruction clock is a free running divide-by-four of the system clock.
	// It keeps its phase across Sleep instead of restarting, so the pin resumes mid-cycle.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			iclk_cnt_r <= 2'h0;
		end else if (!sleep_s) begin
			iclk_cnt_r <= iclk_cnt_r + 2'h1;
		end
	end

	// Sleep stops the count and level registers, so the generator is frozen and holds its levels.
	// A write that lands in Sleep updates the register at once, but the count resumes from
	// where it stood, so the new ratio is only clean from its first wrap.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			cnt_r <= '0;
			ref_r <= 1'b0;
		end else if (!sleep_s) begin
			cnt_r <= cnt_nxt;
			ref_r <= ref_nxt;
		end
	end

	// Pin owner in order of precedence: crystal, instruction clock, reference clock.
	// The crystal comes first because any drive on its pin would stall the oscillator.
	always_comb begin
		if (!settled) begin
			pin_src_nxt = PIN_IDLE;
		end else if (xtal_s) begin
			pin_src_nxt = PIN_OSC_INPUT;
		end else if (!cfg_s) begin
			pin_src_nxt = PIN_INSTR_CLK;
		end else if (ctrl_r.module_on_bit && ctrl_r.pin_drive_bit) begin
			pin_src_nxt = PIN_REF_CLK;
		end else begin
			pin_src_nxt = PIN_IDLE;
		end
	end

	always_comb begin
		pin_nxt = '0;
		unique case (pin_src_nxt)
			PIN_IDLE: begin
				pin_nxt = '0;
			end
			PIN_OSC_INPUT: begin
				pin_nxt = '0;
			end
			PIN_INSTR_CLK: begin
				pin_nxt.o  = iclk_cnt_r[1];
				pin_nxt.oe = 1'b1;
			end
			PIN_REF_CLK: begin
				pin_nxt.o  = ref_nxt;
				pin_nxt.oe = 1'b1;
			end
		endcase
	end

	// The pin keeps its level in Sleep like the pad and clock outputs; the bus outputs keep running.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			pin_r <= '0;
		end else if (!sleep_s) begin
			pin_r <= pin_nxt;
		end
	end

	// Pad controls. Slew limiting matters only while the pin is driven, but it follows the
	// register one cycle later whether the pin is driven or not, and holds its level in Sleep.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			DIVIDED_CLOCK_PIN_O  <= 1'b0;
			DIVIDED_CLOCK_PIN_OE <= 1'b0;
			SLEW_LIMIT           <= 1'b1;
			OSC_PIN_IS_INPUT     <= 1'b0;
			MOD_REF_CLK          <= 1'b0;
		end else if (!sleep_s) begin
			DIVIDED_CLOCK_PIN_O  <= pin_nxt.o;
			DIVIDED_CLOCK_PIN_OE <= pin_nxt.oe;
			SLEW_LIMIT           <= ctrl_r.slew_limit_bit;
			OSC_PIN_IS_INPUT     <= (pin_src_nxt == PIN_OSC_INPUT);
			MOD_REF_CLK          <= ref_nxt;
		end
	end

endmodule // refclk_gen

/* File: dv/refclk_far_end.sv */
// Model of the shared pin's far side and of the modulator input.
`timescale 1ns/1ps
module refclk_far_end (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst,
	// Pin drive and generated clock from the block.
	input  wire logic pin_o,
	input  wire logic pin_oe,
	input  wire logic mod_clk,
	// Pin level seen outside and modulator edge count.
	output logic      pin_level,
	output int        mod_rises
);
	logic last_r;
	logic mod_r;
	// A released pin belongs to the crystal, which keeps swinging.
	assign pin_level = pin_oe ? pin_o : ~last_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) last_r <= 1'h0;
		else last_r <= pin_level;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mod_r <= 1'h0;
			mod_rises <= 0;
		end else begin
			mod_r <= mod_clk;
			if (mod_clk && !mod_r) mod_rises <= mod_rises + 1;
		end
	end
endmodule // refclk_far_end

/* File: dv/refclk_gen_checker.sv */
// Port-level checks of the reference clock generator.
`timescale 1ns/1ps
`include "refclk_regs.svh"
module refclk_gen_checker import refclk_pkg::*; (
	input wire logic        CLK,
	input wire logic        RST,
	input wire logic        HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0]  HTRANS,
	input wire logic        HWRITE,
	input wire logic [2:0]  HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic        HREADY,
	input wire logic [31:0] HRDATA,
	input wire osc_mode_t   OSC_MODE,
	input wire logic        INSTRUCTION_CLOCK_OUTPUT_CONFIG,
	input wire logic        SLEEP,
	input wire logic        DIVIDED_CLOCK_PIN_O,
	input wire logic        DIVIDED_CLOCK_PIN_OE,
	input wire logic        SLEW_LIMIT,
	input wire logic        OSC_PIN_IS_INPUT,
	input wire logic        MOD_REF_CLK
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	ctrl_t      sh_r;
	logic       av_r;
	logic       aw_r;
	logic [7:0] aa_r;
	logic [1:0] skip_r;
	logic       fall;
	logic [7:0] hi_r;
	logic [7:0] exp_hi;
	logic       load;
	assign load = av_r && aw_r && aa_r == `REFCLK_CTRL_OFS && HREADY;
	assign fall = hi_r != 8'h00 && !MOD_REF_CLK;
	// Divide by two cannot show a quarter period, so every nonzero duty is one cycle high.
	assign exp_hi = (sh_r.divide_select_field == 3'h1) ? 8'h01 :
		8'(((9'h001 << sh_r.divide_select_field) * sh_r.duty_select_field) >> 2);
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			av_r <= 1'h0;
			aw_r <= 1'h0;
			aa_r <= 8'h00;
		end else if (HREADY) begin
			av_r <= HSEL && HTRANS == 2'h2 && HSIZE == 3'h2;
			aw_r <= HWRITE;
			aa_r <= HADDR[7:0];
		end
	end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) sh_r <= `REFCLK_CTRL_RST;
		else if (load) sh_r <= HWDATA[7:0];
	end
	always_ff @(posedge CLK or posedge RST) begin
		// The fall that a write forces and the short first high phase after it are skipped.
		if (RST) begin
			skip_r <= 2'h2;
			hi_r <= 8'h00;
		end else begin
			if (load || SLEEP) skip_r <= 2'h2;
			else if (fall && skip_r != 2'h0) skip_r <= skip_r - 2'h1;
			hi_r <= MOD_REF_CLK ? hi_r + 8'h01 : 8'h00;
		end
	end
	a_xtal_pin_free: assert property (OSC_PIN_IS_INPUT |-> !DIVIDED_CLOCK_PIN_OE)
		else $error("pin driven while held as oscillator input");
	a_xtal_owns_pin: assert property ((!SLEEP && (OSC_MODE == OSC_LOW_POWER_CRYSTAL ||
		OSC_MODE == OSC_STANDARD_CRYSTAL || OSC_MODE == OSC_HIGH_SPEED_CRYSTAL))[*5]
		|-> OSC_PIN_IS_INPUT && !DIVIDED_CLOCK_PIN_OE)
		else $error("crystal mode but pin not held as oscillator input");
	a_iclk_on_pin: assert property ((!INSTRUCTION_CLOCK_OUTPUT_CONFIG && !SLEEP &&
		DIVIDED_CLOCK_PIN_OE)[*5] ##0 $rose(DIVIDED_CLOCK_PIN_O) |=> DIVIDED_CLOCK_PIN_O
		##1 (!DIVIDED_CLOCK_PIN_O)[*2] ##1 DIVIDED_CLOCK_PIN_O)
		else $error("instruction clock shape wrong on pin");
	a_ref_on_pin: assert property ((INSTRUCTION_CLOCK_OUTPUT_CONFIG && !SLEEP)[*5]
		##0 DIVIDED_CLOCK_PIN_OE |-> DIVIDED_CLOCK_PIN_O == MOD_REF_CLK)
		else $error("pin differs from generated clock");
	a_off_quiet: assert property ((!SLEEP)[*5] ##0 (!sh_r.module_on_bit ||
		sh_r.duty_select_field == 2'h0)[*2] |-> !MOD_REF_CLK)
		else $error("generated clock high while off or at zero duty");
	a_slew_follow: assert property ((!SLEEP)[*5] ##0 ($stable(sh_r))[*2]
		|-> SLEW_LIMIT == sh_r.slew_limit_bit) else $error("slew output wrong");
	a_sleep_hold: assert property (SLEEP[*4] |-> $stable(MOD_REF_CLK) &&
		$stable(DIVIDED_CLOCK_PIN_O) && $stable(SLEW_LIMIT)) else $error("output moved in sleep");
	a_high_time: assert property ($fell(MOD_REF_CLK) && skip_r == 2'h0 |-> hi_r == exp_hi)
		else $error("generated clock high time wrong");
	a_base_follow: assert property ((sh_r.module_on_bit && !SLEEP && !load &&
		sh_r.divide_select_field == 3'h0 && sh_r.duty_select_field != 2'h0)[*5] |-> MOD_REF_CLK)
		else $error("undivided clock not high");
	a_ctrl_readback: assert property (av_r && !aw_r && aa_r == `REFCLK_CTRL_OFS
		|-> HRDATA == {24'h000000, sh_r}) else $error("control read back wrong");
	c_period: cover property ($fell(MOD_REF_CLK) && skip_r == 2'h0);
	c_sleep: cover property (SLEEP[*4]);
	c_iclk: cover property (!INSTRUCTION_CLOCK_OUTPUT_CONFIG && $rose(DIVIDED_CLOCK_PIN_O));
endmodule // refclk_gen_checker

bind refclk_gen refclk_gen_checker chk (.CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE,
	.HWDATA, .HREADY, .HRDATA, .OSC_MODE, .INSTRUCTION_CLOCK_OUTPUT_CONFIG, .SLEEP,
	.DIVIDED_CLOCK_PIN_O, .DIVIDED_CLOCK_PIN_OE, .SLEW_LIMIT, .OSC_PIN_IS_INPUT, .MOD_REF_CLK);

/* File: dv/test_reference_clock_output_generator.sv */
// Self-checking bench for the reference clock generator.
`timescale 1ns/1ps
`include "refclk_regs.svh"
module test_reference_clock_output_generator;
	import refclk_pkg::*;
	logic        clk;
	logic        rst;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	osc_mode_t   osc;
	logic        cfg;
	logic        sleep_in;
	logic        pin_o;
	logic        pin_oe;
	logic        slew;
	logic        is_in;
	logic        mod;
	logic        pin_lvl;
	int          rises;
	logic [31:0] q;
	int          miscompares;
	int          num_checks;
	refclk_gen dut (.CLK(clk), .RST(rst), .HSEL(1'h1), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
		.HREADYOUT(hreadyout), .HRESP(hresp), .OSC_MODE(osc),
		.INSTRUCTION_CLOCK_OUTPUT_CONFIG(cfg),
		.SLEEP(sleep_in), .DIVIDED_CLOCK_PIN_O(pin_o), .DIVIDED_CLOCK_PIN_OE(pin_oe),
		.SLEW_LIMIT(slew), .OSC_PIN_IS_INPUT(is_in), .MOD_REF_CLK(mod));
	refclk_far_end far (.clk(clk), .rst(rst), .pin_o(pin_o), .pin_oe(pin_oe), .mod_clk(mod),
		.pin_level(pin_lvl), .mod_rises(rises));
	task automatic complete_run;
		if (miscompares == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'h1 && n < 64);
		if (n >= 64) begin
			miscompares++;
			complete_run();
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
	endtask
	// Counts high samples of the generated clock, or of the pin when sel is set.
	task automatic measure(input logic sel, input int n, output int h);
		h = 0;
		repeat (n) begin
			@(posedge clk);
			if ((sel ? pin_lvl : mod) === 1'h1) h++;
		end
	endtask
	task automatic reset_values;
		xfer(1'h0, `REFCLK_CTRL_OFS, 32'h0);
		check(q, 32'h00000030);
		check(32'(slew), 32'h1);
		check(32'(hresp), 32'h0);
		xfer(1'h1, 8'h08, 32'h000000FF);
		xfer(1'h0, 8'h08, 32'h0);
		check(q, 32'h0);
	endtask
	task automatic dividers;
		int h;
		int e;
		int n;
		for (int v = 0; v < 32; v++) begin
			n = 1 << v[2:0];
			xfer(1'h1, `REFCLK_CTRL_OFS, {24'h000000, 2'h3, v[0], v[4:0]});
			repeat (4) @(posedge clk);
			check(32'(slew), 32'(v[0]));
			check(32'(pin_oe), 32'h1);
			measure(1'h0, 2 * n, h);
			e = (v[4:3] == 0) ? 0 : (n < 4) ? 2 : n * v[4:3] / 2;
			check(h, e);
		end
		xfer(1'h1, `REFCLK_CTRL_OFS, 32'h00000053);
		measure(1'h0, 16, h);
		check(h, 0);
		xfer(1'h1, `REFCLK_CTRL_OFS, 32'h000000B3);
		// The write cycle is forced low, so the window opens once the period runs clean.
		repeat (2) @(posedge clk);
		measure(1'h0, 16, h);
		check(h, 8);
		check(32'(pin_oe), 32'h0);
	endtask
	task automatic crystal;
		int r;
		xfer(1'h1, `REFCLK_CTRL_OFS, 32'h000000D3);
		for (int m = 0; m < 3; m++) begin
			osc <= osc_mode_t'(m);
			repeat (6) @(posedge clk);
			r = rises;
			repeat (16) @(posedge clk);
			check(rises - r, 2);
			check({is_in, pin_oe}, 32'h2);
			xfer(1'h0, `REFCLK_STAT_OFS, 32'h0);
			check(q & 32'h000000FE, 32'h00000048);
		end
		osc <= OSC_INTERNAL;
	endtask
	task automatic sleep_hold;
		logic [2:0] m0;
		sleep_in <= 1'h1;
		repeat (4) @(posedge clk);
		m0 = {pin_o, mod, slew};
		xfer(1'h1, `REFCLK_CTRL_OFS, 32'h00000007);
		xfer(1'h0, `REFCLK_STAT_OFS, 32'h0);
		check(q & 32'h00000060, 32'h00000020);
		repeat (20) @(posedge clk);
		check({pin_o, mod, slew}, m0);
		sleep_in <= 1'h0;
		repeat (6) @(posedge clk);
		check({mod, slew}, 32'h0);
	endtask
	task automatic instr_clock;
		int h;
		cfg <= 1'h0;
		for (int k = 0; k < 2; k++) begin
			xfer(1'h1, `REFCLK_CTRL_OFS, k ? 32'h000000DB : 32'h0);
			repeat (6) @(posedge clk);
			measure(1'h1, 16, h);
			check(h, 8);
			check(32'(pin_oe), 32'h1);
		end
	endtask
	task automatic mid_reset;
		rst <= 1'h1;
		cfg <= 1'h1;
		repeat (3) @(posedge clk);
		check({mod, pin_oe}, 32'h0);
		rst <= 1'h0;
		@(posedge clk);
		xfer(1'h0, `REFCLK_CTRL_OFS, 32'h0);
		check(q, 32'h00000030);
	endtask
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	initial begin
		rst = 1'h1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hwdata = 32'h0;
		osc = OSC_INTERNAL;
		cfg = 1'h1;
		sleep_in = 1'h0;
		miscompares = 0;
		num_checks = 0;
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		reset_values();
		dividers();
		crystal();
		sleep_hold();
		instr_clock();
		mid_reset();
		complete_run();
	end
endmodule // test_reference_clock_output_generator
